// file: logic/dds_params.svh
// constants for the door drive status and battery supervisor
// assumes a 100 MHz hclk and battery voltage supplied in millivolts
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH
// ==========================================================
// clock and timing
`define DDS_CLK_MHZ 100
`define DDS_BLINK_MS 500
`define DDS_LAMP_MS 1000
`define DDS_SEC_MS 1000
`define DDS_CHARGE_H 10
// ==========================================================
// battery thresholds in millivolts
`define DDS_MV_ABSENT 16'd5000
`define DDS_MV_CHARGING 16'd24500
`define DDS_MV_CHARGED 16'd25500
`define DDS_MV_ACTIVE 16'd22000
// ==========================================================
// register byte offsets
`define DDS_OFS_CTRL 4'h0
`define DDS_OFS_STATUS 4'h4
`define DDS_OFS_VBAT 4'h8
`define DDS_OFS_CHARGE 4'hc
`define DDS_CTRL_RST 4'h0
// ==========================================================
// segment patterns, bit order gfedcba
`define SEG_0 7'h3f
`define SEG_1 7'h06
`define SEG_2 7'h5b
`define SEG_3 7'h4f
`define SEG_4 7'h66
`define SEG_5 7'h6d
`define SEG_6 7'h7d
`define SEG_7 7'h07
`define SEG_8 7'h7f
`define SEG_9 7'h6f
`define SEG_A 7'h77
`define SEG_B 7'h7c
`define SEG_C 7'h39
`define SEG_D 7'h5e
`define SEG_E 7'h79
`define SEG_F 7'h71
`define SEG_L 7'h38
`define SEG_P 7'h73
`define SEG_R 7'h50
`define SEG_N 7'h54
`define SEG_H 7'h76
`define SEG_U 7'h3e
`define SEG_OFF 7'h00
`endif

// file: logic/dds_pkg.sv
// types shared by the door drive status and battery supervisor
// assumes nothing beyond a SystemVerilog compiler
package dds_pkg;
  // ==========================================================
  // battery classification
  typedef enum logic [4:0] {
    DDS_BAT_ABSENT = 5'h01,
    DDS_BAT_CHARGING = 5'h02,
    DDS_BAT_CHARGED = 5'h04,
    DDS_BAT_ACTIVE = 5'h08,
    DDS_BAT_INACTIVE = 5'h10
  } dds_bat_e;
  typedef logic [6:0] dds_seg_t;
endpackage

// file: logic/dds_door_supervisor.sv
// door drive panel code selection and battery supervision
// assumes pins synchronous to hclk, one AHB-Lite master, battery in mV
//
// Overview of operation
// - below 5 V battery counts as absent
// - mains and below 24.5 V means charging
// - charged at 25.5 V or 10 h charging
// - mains off above 22 V: reduced-speed battery run
// - mains off at or below 22 V: halt, open clutch if door locked
// - two-digit display content follows working mode
// - opening blinks, opened shows steady
// - closing blinks, closed shows steady
// - learning code, second code on second travel
// - learning error aborts, alternates code and number
// - alarm code alternates with alarm number
// - forced close shows blinking code
// - reversing blinks, steady with external source when opened
// - both commands give stop and stop code
// - torque disabled shows no-torque code
// - wireless mode shows its code
// - firmware upgrade shows upgrade code
// - handset on diagnostic port shows its code
// - mains absent, residual charge: standby code
// - power-on lamp test lights all segments
// - off state dark, on key resumes
// - idle intermediate without command shows blank
// - inspection ignores controller commands, uses keys
`timescale 1ns/1ns
`include "dds_params.svh"
module dds_door_supervisor
  import dds_pkg::*;
#(
  parameter int BLINK_CYCLES = `DDS_BLINK_MS * 1000 * `DDS_CLK_MHZ,
  parameter int LAMP_CYCLES = `DDS_LAMP_MS * 1000 * `DDS_CLK_MHZ,
  parameter int SEC_CYCLES = `DDS_SEC_MS * 1000 * `DDS_CLK_MHZ,
  parameter int CHARGE_S = `DDS_CHARGE_H * 3600
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mains_present_in,
  input wire logic [15:0] battery_mv_in,
  input wire logic door_locked_in,
  input wire logic open_command_in,
  input wire logic close_command_in,
  input wire logic second_travel_command_in,
  input wire logic key_open_in,
  input wire logic key_close_in,
  input wire logic key_on_in,
  input wire logic opening_in,
  input wire logic opened_in,
  input wire logic closing_in,
  input wire logic closed_in,
  input wire logic learning_in,
  input wire logic learn_start_in,
  input wire logic learn_error_in,
  input wire logic [7:0] error_number_in,
  input wire logic alarm_in,
  input wire logic [7:0] alarm_number_in,
  input wire logic forced_close_in,
  input wire logic reversing_in,
  input wire logic ext_reverse_in,
  input wire logic torque_off_in,
  input wire logic handset_present_in,
  output logic door_open_out,
  output logic door_close_out,
  output logic stop_out,
  output logic battery_mode_out,
  output logic reduced_speed_out,
  output logic clutch_release_out,
  output logic halt_out,
  output logic learn_abort_out,
  output logic normal_led_out,
  output dds_bat_e battery_state_out,
  output dds_seg_t seg_hi_out,
  output dds_seg_t seg_lo_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // AHB-Lite slave, zero wait, always OKAY
  logic wr_pend_q;
  logic [3:0] wr_ofs_q;
  logic [3:0] ctrl_q;
  logic [31:0] status_w;
  logic [15:0] chg_s_q;
  logic [31:0] rd_d;
  logic acc;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready;

  always_comb begin
    rd_d = 32'h0;
    unique case (haddr[3:0])
      `DDS_OFS_CTRL: rd_d = {28'h0, ctrl_q};
      `DDS_OFS_STATUS: rd_d = status_w;
      `DDS_OFS_VBAT: rd_d = {16'h0, battery_mv_in};
      `DDS_OFS_CHARGE: rd_d = {16'h0, chg_s_q};
      default: rd_d = 32'h0;
    endcase
    if (haddr[31:4] != 28'h0) begin
      rd_d = 32'h0;
    end
  end

  // read data is captured at the address edge so no wait state is needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 4'h0;
    end else begin
      wr_pend_q <= acc && hwrite && (haddr[31:4] == 28'h0);
      wr_ofs_q <= haddr[3:0];
    end
  end

  // ctrl: [0] inspection, [1] wireless, [2] upgrade, [3] drive off
  // the on key wins over a software write of the off bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `DDS_CTRL_RST;
    end else begin
      if (wr_pend_q && wr_ofs_q == `DDS_OFS_CTRL) begin
        ctrl_q <= hwdata[3:0];
      end
      if (key_on_in) begin
        ctrl_q[3] <= 1'b0;
      end
    end
  end

  logic insp, wireless, upgrade, drive_off;
  assign insp = ctrl_q[0];
  assign wireless = ctrl_q[1];
  assign upgrade = ctrl_q[2];
  assign drive_off = ctrl_q[3];

  // ==========================================================
  // command steering
  logic open_src, close_src;
  assign open_src = insp ? key_open_in : open_command_in;
  assign close_src = insp ? key_close_in : close_command_in;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      door_open_out <= 1'b0;
      door_close_out <= 1'b0;
      stop_out <= 1'b0;
    end else begin
      stop_out <= open_src && close_src;
      door_open_out <= open_src && !close_src && !drive_off;
      door_close_out <= close_src && !open_src && !drive_off;
    end
  end

  // ==========================================================
  // battery classification and charge timer
  dds_bat_e bat_q, bat_d;
  logic [31:0] sec_cnt_q;
  logic sec_tick;
  logic v_absent, v_low, v_full, v_active;
  assign v_absent = battery_mv_in < `DDS_MV_ABSENT;
  assign v_low = battery_mv_in < `DDS_MV_CHARGING;
  assign v_full = battery_mv_in >= `DDS_MV_CHARGED;
  assign v_active = battery_mv_in > `DDS_MV_ACTIVE;
  assign sec_tick = sec_cnt_q == 32'(SEC_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_q <= 32'h0;
    end else begin
      sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end

  // any interruption of charging restarts the time count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_s_q <= 16'h0;
    end else if (bat_q != DDS_BAT_CHARGING || !mains_present_in) begin
      chg_s_q <= 16'h0;
    end else if (sec_tick && chg_s_q != 16'(CHARGE_S)) begin
      chg_s_q <= chg_s_q + 16'h1;
    end
  end

  always_comb begin
    bat_d = bat_q;
    if (v_absent) begin
      bat_d = DDS_BAT_ABSENT;
    end else if (!mains_present_in) begin
      bat_d = v_active ? DDS_BAT_ACTIVE : DDS_BAT_INACTIVE;
    end else if (v_full || chg_s_q == 16'(CHARGE_S)) begin
      bat_d = DDS_BAT_CHARGED;
    end else if (v_low) begin
      bat_d = DDS_BAT_CHARGING;
    end else if (bat_q != DDS_BAT_CHARGED) begin
      bat_d = DDS_BAT_CHARGING;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bat_q <= DDS_BAT_ABSENT;
    end else begin
      bat_q <= bat_d;
    end
  end

  logic bat_run;
  assign bat_run = bat_q == DDS_BAT_ACTIVE;
  assign battery_state_out = bat_q;
  assign battery_mode_out = bat_run;
  assign reduced_speed_out = bat_run;

  // with mains off and no usable battery the clutch opens if the door is locked, and all stops in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clutch_release_out <= 1'b0;
      halt_out <= 1'b0;
    end else begin
      clutch_release_out <= !mains_present_in && !v_active &&
                            door_locked_in;
      halt_out <= !mains_present_in && !v_active;
    end
  end

  // ==========================================================
  // learning error latch, set wins over restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      learn_abort_out <= 1'b0;
    end else if (learn_error_in) begin
      learn_abort_out <= 1'b1;
    end else if (learn_start_in) begin
      learn_abort_out <= 1'b0;
    end
  end

  // ==========================================================
  // lamp test and shared toggle
  logic [31:0] lamp_cnt_q, blink_cnt_q;
  logic lamp_q, blink_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_cnt_q <= 32'h0;
      lamp_q <= 1'b1;
    end else if (lamp_q) begin
      lamp_cnt_q <= lamp_cnt_q + 32'h1;
      lamp_q <= lamp_cnt_q != 32'(LAMP_CYCLES - 1);
    end
  end

  // one period for blinking and alternating keeps the panel coherent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b1;
    end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_q <= 32'h0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // display selection, first match wins
  function automatic dds_seg_t hex7(input logic [3:0] v);
    unique case (v)
      4'h0: hex7 = `SEG_0;
      4'h1: hex7 = `SEG_1;
      4'h2: hex7 = `SEG_2;
      4'h3: hex7 = `SEG_3;
      4'h4: hex7 = `SEG_4;
      4'h5: hex7 = `SEG_5;
      4'h6: hex7 = `SEG_6;
      4'h7: hex7 = `SEG_7;
      4'h8: hex7 = `SEG_8;
      4'h9: hex7 = `SEG_9;
      4'ha: hex7 = `SEG_A;
      4'hb: hex7 = `SEG_B;
      4'hc: hex7 = `SEG_C;
      4'hd: hex7 = `SEG_D;
      4'he: hex7 = `SEG_E;
      4'hf: hex7 = `SEG_F;
    endcase
  endfunction

  dds_seg_t hi_d, lo_d;
  logic blank_d;
  logic standby;
  assign standby = !mains_present_in && !bat_run;

  always_comb begin
    hi_d = `SEG_OFF;
    lo_d = `SEG_OFF;
    blank_d = 1'b0;
    if (lamp_q) begin
      hi_d = `SEG_8;
      lo_d = `SEG_8;
    end else if (drive_off) begin
      hi_d = `SEG_OFF;
    end else if (upgrade) begin
      hi_d = `SEG_U;
      lo_d = `SEG_P;
    end else if (handset_present_in) begin
      hi_d = `SEG_H;
      lo_d = `SEG_5;
    end else if (learn_abort_out) begin
      hi_d = blink_q ? `SEG_E : hex7(error_number_in[7:4]);
      lo_d = blink_q ? `SEG_R : hex7(error_number_in[3:0]);
    end else if (learning_in) begin
      hi_d = `SEG_5;
      lo_d = second_travel_command_in ? `SEG_2 : `SEG_L;
    end else if (alarm_in) begin
      hi_d = blink_q ? `SEG_A : hex7(alarm_number_in[7:4]);
      lo_d = blink_q ? `SEG_L : hex7(alarm_number_in[3:0]);
    end else if (standby) begin
      hi_d = `SEG_5;
      lo_d = `SEG_B;
    end else if (stop_out) begin
      hi_d = `SEG_B;
      lo_d = `SEG_L;
    end else if (torque_off_in) begin
      hi_d = `SEG_N;
      lo_d = `SEG_E;
    end else if (wireless) begin
      hi_d = `SEG_U;
      lo_d = `SEG_F;
    end else if (forced_close_in) begin
      hi_d = `SEG_F;
      lo_d = `SEG_C;
      blank_d = !blink_q;
    end else if (reversing_in || (ext_reverse_in && opened_in)) begin
      hi_d = `SEG_R;
      lo_d = `SEG_U;
      blank_d = reversing_in && !blink_q;
    end else if (opening_in || opened_in) begin
      hi_d = `SEG_0;
      lo_d = `SEG_P;
      blank_d = opening_in && !blink_q;
    end else if (closing_in || closed_in) begin
      hi_d = `SEG_C;
      lo_d = `SEG_L;
      blank_d = closing_in && !blink_q;
    end else begin
      hi_d = `SEG_OFF;
    end
  end

  // content depends on the mode bits held in ctrl
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_hi_out <= `SEG_8;
      seg_lo_out <= `SEG_8;
    end else begin
      seg_hi_out <= blank_d ? `SEG_OFF : hi_d;
      seg_lo_out <= blank_d ? `SEG_OFF : lo_d;
    end
  end

  assign normal_led_out = !insp;

  // status: [4:0] battery, [5] battery run, [6] halt, [7] stop,
  // [8] lamp test, [9] learn abort, [22:16] hi, [30:24] lo
  assign status_w = {1'b0, seg_lo_out, 1'b0, seg_hi_out, 6'h0,
                     learn_abort_out, lamp_q, stop_out, halt_out,
                     bat_run, bat_q};

  // ==========================================================
  // checks
  logic quiet;
  assign quiet = !lamp_q && !drive_off && !upgrade &&
                 !handset_present_in && !learn_abort_out &&
                 !learning_in && !alarm_in && !standby;

  property p_absent;
    v_absent |=> bat_q == DDS_BAT_ABSENT;
  endproperty
  a_absent: assert property (p_absent)
    else $error("low battery not absent");

  property p_charging;
    mains_present_in && !v_absent && v_low && chg_s_q != 16'(CHARGE_S)
      |=> bat_q == DDS_BAT_CHARGING;
  endproperty
  a_charging: assert property (p_charging)
    else $error("not charging below threshold");

  property p_charged;
    mains_present_in && !v_absent && (v_full || chg_s_q == 16'(CHARGE_S))
      |=> bat_q == DDS_BAT_CHARGED && !reduced_speed_out;
  endproperty
  a_charged: assert property (p_charged)
    else $error("charged state missed");

  property p_bat_run;
    !mains_present_in && v_active |=> battery_mode_out && reduced_speed_out;
  endproperty
  a_bat_run: assert property (p_bat_run)
    else $error("battery run missed");

  property p_halt;
    !mains_present_in && !v_active && door_locked_in
      |=> clutch_release_out && halt_out && !battery_mode_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("clutch or halt missed");

  property p_lamp;
    $fell(lamp_q) |-> $past(seg_hi_out) == `SEG_8 &&
                      $past(seg_lo_out) == `SEG_8;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp test pattern missing");

  property p_stop;
    quiet && stop_out |=> seg_hi_out == `SEG_B && seg_lo_out == `SEG_L;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop code missing");

  property p_insp;
    insp && key_open_in && !key_close_in && !drive_off |=> door_open_out;
  endproperty
  a_insp: assert property (p_insp)
    else $error("inspection key ignored");

  property p_off;
    !lamp_q && drive_off |=> seg_hi_out == `SEG_OFF &&
                             seg_lo_out == `SEG_OFF;
  endproperty
  a_off: assert property (p_off)
    else $error("display not dark when off");

  property p_key_on;
    key_on_in |=> !drive_off;
  endproperty
  a_key_on: assert property (p_key_on)
    else $error("on key did not resume");

  property p_err_latch;
    learn_error_in |=> learn_abort_out [*2] or
                       (learn_abort_out ##1 $past(learn_start_in));
  endproperty
  a_err_latch: assert property (p_err_latch)
    else $error("learning abort not held");

  c_charged: cover property (bat_q == DDS_BAT_CHARGED);
  c_bat_run: cover property (battery_mode_out ##1 door_open_out);
  c_stop: cover property (quiet && stop_out);
  c_err: cover property (learn_abort_out && $changed(blink_q));
endmodule // dds_door_supervisor

// file: logic/dds_unused_placeholder_removed.sv
// intentionally empty: no further logic
`timescale 1ns/1ns

// file: test/dds_lift_ctrl_model.sv
// elevator controller model: drives the door open and close commands
// assumes the hclk domain; a request shows after lag + 1 edges
`timescale 1ns/1ns
module dds_lift_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] req,
  input wire logic [3:0] lag,
  output logic open_cmd,
  output logic close_cmd
);
  // ==========================================================
  // command levels
  logic [3:0] cnt_q;
  // a slow controller shows a new request only after lag + 1 edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      open_cmd <= 1'b0;
      close_cmd <= 1'b0;
    end else if (req == {close_cmd, open_cmd}) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= lag) begin
      {close_cmd, open_cmd} <= req;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // dds_lift_ctrl_model

// file: test/dds_door_supervisor_tb.sv
// testbench for the door drive status and battery supervisor
// assumes 100 MHz hclk, short counts set through the parameters
`timescale 1ns/1ns
`include "dds_params.svh"
module dds_door_supervisor_tb
  import dds_pkg::*;
;
  // ==========================================================
  // signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, req;
  logic [2:0] hsize;
  logic [3:0] lag;
  logic [15:0] battery_mv_in;
  logic [7:0] error_number_in, alarm_number_in;
  logic mains_present_in, door_locked_in, open_command_in;
  logic close_command_in, second_travel_command_in, key_open_in;
  logic key_close_in, key_on_in, opening_in, opened_in, closing_in;
  logic closed_in, learning_in, learn_start_in, learn_error_in;
  logic alarm_in, forced_close_in, reversing_in, ext_reverse_in;
  logic torque_off_in, handset_present_in;
  logic door_open_out, door_close_out, stop_out, battery_mode_out;
  logic reduced_speed_out, clutch_release_out, halt_out;
  logic learn_abort_out, normal_led_out;
  dds_bat_e battery_state_out;
  dds_seg_t seg_hi_out, seg_lo_out;
  int errors = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  dds_door_supervisor #(.BLINK_CYCLES(4), .LAMP_CYCLES(8),
    .SEC_CYCLES(4), .CHARGE_S(3)) dds_door_supervisor_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .mains_present_in,
    .battery_mv_in, .door_locked_in, .open_command_in, .close_command_in,
    .second_travel_command_in, .key_open_in, .key_close_in, .key_on_in,
    .opening_in, .opened_in, .closing_in, .closed_in, .learning_in,
    .learn_start_in, .learn_error_in, .error_number_in, .alarm_in,
    .alarm_number_in, .forced_close_in, .reversing_in, .ext_reverse_in,
    .torque_off_in, .handset_present_in, .door_open_out,
    .door_close_out, .stop_out, .battery_mode_out, .reduced_speed_out,
    .clutch_release_out, .halt_out, .learn_abort_out, .normal_led_out,
    .battery_state_out, .seg_hi_out, .seg_lo_out);
  dds_lift_ctrl_model dds_lift_ctrl_model_inst (.hclk, .hresetn, .req,
    .lag, .open_cmd(open_command_in), .close_cmd(close_command_in));
  // ==========================================================
  // table: fl bits 0 opened 1 closed 2 no torque 3 handset
  // 4 learning 5 second travel 6 open cmd 7 close cmd
  typedef struct {
    logic mains;
    logic [15:0] mv;
    logic [7:0] fl;
    logic [3:0] ctrl;
    dds_bat_e bat;
    dds_seg_t hi;
    dds_seg_t lo;
  } dds_row_s;
  dds_row_s rows [12] = '{
    '{1'b1, 16'd4000, 8'h00, 4'h0, DDS_BAT_ABSENT, `SEG_OFF, `SEG_OFF},
    '{1'b1, 16'd24000, 8'h01, 4'h0, DDS_BAT_CHARGING, `SEG_0, `SEG_P},
    '{1'b1, 16'd25000, 8'h02, 4'h0, DDS_BAT_CHARGED, `SEG_C, `SEG_L},
    '{1'b1, 16'd25500, 8'hc0, 4'h0, DDS_BAT_CHARGED, `SEG_B, `SEG_L},
    '{1'b1, 16'd25500, 8'h04, 4'h0, DDS_BAT_CHARGED, `SEG_N, `SEG_E},
    '{1'b1, 16'd25500, 8'h00, 4'h2, DDS_BAT_CHARGED, `SEG_U, `SEG_F},
    '{1'b1, 16'd25500, 8'h08, 4'h4, DDS_BAT_CHARGED, `SEG_U, `SEG_P},
    '{1'b1, 16'd25500, 8'h08, 4'h0, DDS_BAT_CHARGED, `SEG_H, `SEG_5},
    '{1'b1, 16'd25500, 8'h10, 4'h0, DDS_BAT_CHARGED, `SEG_5, `SEG_L},
    '{1'b1, 16'd25500, 8'h30, 4'h0, DDS_BAT_CHARGED, `SEG_5, `SEG_2},
    '{1'b0, 16'd23000, 8'h01, 4'h0, DDS_BAT_ACTIVE, `SEG_0, `SEG_P},
    '{1'b0, 16'd21000, 8'h01, 4'h0, DDS_BAT_INACTIVE, `SEG_5, `SEG_B}};
  dds_row_s r;
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    tests_run++;
    if (e !== s) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // blinking and alternating both must show each face within 16 edges
  task automatic see_two(input dds_seg_t ah, al, bh, bl);
    int sa;
    int sb;
    sa = 0;
    sb = 0;
    repeat (16) begin
      @(negedge hclk);
      if (seg_hi_out === ah && seg_lo_out === al) sa++;
      if (seg_hi_out === bh && seg_lo_out === bl) sb++;
    end
    chk("two_faces", 32'h1, {31'h0, sa > 0 && sb > 0});
    @(posedge hclk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, req, lag} = '0;
    hsize = 3'h2;
    {opening_in, opened_in, closing_in, closed_in, learning_in} = '0;
    {key_open_in, key_close_in, key_on_in, alarm_in} = '0;
    {learn_start_in, learn_error_in, forced_close_in} = '0;
    {reversing_in, ext_reverse_in, torque_off_in} = '0;
    {handset_present_in, second_travel_command_in} = '0;
    {error_number_in, alarm_number_in} = '0;
    mains_present_in = 1'b1;
    battery_mv_in = 16'd4000;
    door_locked_in = 1'b1;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    chk("seg_hi_rst", `SEG_8, seg_hi_out);
    chk("seg_lo_rst", `SEG_8, seg_lo_out);
    chk("bat_rst", DDS_BAT_ABSENT, battery_state_out);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("lamp", `SEG_8, seg_hi_out);
    repeat (10) @(posedge hclk);
    chk("lamp_end", `SEG_OFF, seg_lo_out);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge hclk);
      mains_present_in <= r.mains;
      battery_mv_in <= r.mv;
      opened_in <= r.fl[0];
      closed_in <= r.fl[1];
      torque_off_in <= r.fl[2];
      handset_present_in <= r.fl[3];
      learning_in <= r.fl[4];
      second_travel_command_in <= r.fl[5];
      req <= r.fl[7:6];
      ahb(1'b1, 32'h0, {28'h0, r.ctrl});
      repeat (5) @(posedge hclk);
      chk("battery", r.bat, battery_state_out);
      chk("seg_hi", r.hi, seg_hi_out);
      chk("seg_lo", r.lo, seg_lo_out);
      chk("stop", r.fl[7] & r.fl[6], stop_out);
      chk("reduced", r.bat == DDS_BAT_ACTIVE, reduced_speed_out);
      chk("bat_run", r.bat == DDS_BAT_ACTIVE, battery_mode_out);
      chk("halt", !r.mains && r.mv <= 16'd22000, halt_out);
      chk("clutch", !r.mains && r.mv <= 16'd22000,
        clutch_release_out);
    end
    @(posedge hclk);
    mains_present_in <= 1'b1;
    battery_mv_in <= 16'd25500;
    {opened_in, closed_in, learning_in, second_travel_command_in} <= '0;
    req <= 2'b00;
    ahb(1'b0, 32'h8, 32'h0);
    chk("vbat", 32'd25500, rd);
    chk("hresp", 32'h0, hresp);
    ahb(1'b0, 32'h4, 32'h0);
    chk("status", 32'h0000_0004, rd);
    ahb(1'b1, 32'h10, 32'hffff_ffff);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    // inspection: the controller asks slowly, only the key may move
    ahb(1'b1, 32'h0, 32'h1);
    lag <= 4'h3;
    req <= 2'b01;
    repeat (10) @(posedge hclk);
    chk("insp_open", 1'b0, door_open_out);
    chk("insp_led", 1'b0, normal_led_out);
    key_open_in <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("key_open", 1'b1, door_open_out);
    key_open_in <= 1'b0;
    ahb(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    chk("norm_open", 1'b1, door_open_out);
    req <= 2'b10;
    repeat (8) @(posedge hclk);
    chk("norm_close", 1'b1, door_close_out);
    chk("norm_close_op", 1'b0, door_open_out);
    req <= 2'b00;
    // off state, then the on key
    opened_in <= 1'b1;
    ahb(1'b1, 32'h0, 32'h8);
    repeat (3) @(posedge hclk);
    chk("off_dark", `SEG_OFF, seg_hi_out);
    chk("off_led", 1'b1, normal_led_out);
    key_on_in <= 1'b1;
    @(posedge hclk);
    key_on_in <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk("on_key", 32'h0, rd);
    repeat (3) @(posedge hclk);
    chk("on_seg", `SEG_0, seg_hi_out);
    opened_in <= 1'b0;
    // learning error, then restart clears the abort
    learning_in <= 1'b1;
    error_number_in <= 8'h3a;
    learn_error_in <= 1'b1;
    @(posedge hclk);
    learn_error_in <= 1'b0;
    see_two(`SEG_E, `SEG_R, `SEG_3, `SEG_A);
    chk("abort", 1'b1, learn_abort_out);
    learn_start_in <= 1'b1;
    @(posedge hclk);
    learn_start_in <= 1'b0;
    learning_in <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("abort_clr", 1'b0, learn_abort_out);
    alarm_in <= 1'b1;
    alarm_number_in <= 8'h5c;
    see_two(`SEG_A, `SEG_L, `SEG_5, `SEG_C);
    alarm_in <= 1'b0;
    opening_in <= 1'b1;
    see_two(`SEG_0, `SEG_P, `SEG_OFF, `SEG_OFF);
    opening_in <= 1'b0;
    closing_in <= 1'b1;
    see_two(`SEG_C, `SEG_L, `SEG_OFF, `SEG_OFF);
    closing_in <= 1'b0;
    forced_close_in <= 1'b1;
    see_two(`SEG_F, `SEG_C, `SEG_OFF, `SEG_OFF);
    forced_close_in <= 1'b0;
    reversing_in <= 1'b1;
    see_two(`SEG_R, `SEG_U, `SEG_OFF, `SEG_OFF);
    reversing_in <= 1'b0;
    ext_reverse_in <= 1'b1;
    opened_in <= 1'b1;
    repeat (3) @(posedge hclk);
    repeat (8) begin
      @(negedge hclk);
      chk("rev_fixed", `SEG_R, seg_hi_out);
    end
    // reset again in mid-run: the lamp test must come back
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst2_hi", `SEG_8, seg_hi_out);
    chk("rst2_led", 1'b1, normal_led_out);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("rst2_lamp", `SEG_8, seg_lo_out);
    complete_run();
  end
endmodule // dds_door_supervisor_tb
